// [common/canmb_pkg.sv]
package canmb_pkg;
  localparam int NumBuffers = 32;
  localparam int WordsPerBuf = 8;
  localparam int BufIdxW = 5;
  localparam int WordIdxW = 3;
  localparam int RamAddrW = 8;
  // Word positions inside one buffer.
  localparam logic [2:0] WordStdId = 3'h0;
  localparam logic [2:0] WordExtId = 3'h1;
  localparam logic [2:0] WordLenCode = 3'h2;
  localparam logic [2:0] WordData01 = 3'h3;
  localparam logic [2:0] WordData67 = 3'h6;
  localparam logic [2:0] WordStatus = 3'h7;
  // Implemented bits of each word; the rest read zero.
  localparam logic [15:0] MaskStdId = 16'h1FFF;
  localparam logic [15:0] MaskExtId = 16'h0FFF;
  localparam logic [15:0] MaskLenCode = 16'hFF1F;
  localparam logic [15:0] MaskData = 16'hFFFF;
  localparam logic [15:0] MaskStatus = 16'h1F00;
  localparam int StdIdLsb = 2;
  localparam int SubRemoteBit = 1;
  localparam int IdFormatBit = 0;
  localparam int ExtHiLsb = 0;
  localparam int ExtLoLsb = 10;
  localparam int RemoteReqBit = 9;
  localparam int ResHighBit = 8;
  localparam int ResLowBit = 4;
  localparam int LenCodeLsb = 0;
  localparam int FilterLsb = 8;
  localparam int FifoDepth = 16;

  typedef struct packed {
    logic [10:0] standardIdentifier;
    logic [17:0] extendedIdentifier;
    logic subRemote;
    logic idExtended;
    logic remoteReq;
    logic [3:0] lenCode;
    logic [63:0] payload;
    logic [4:0] matchedFilterNumber;
    logic [4:0] bufIndex;
  } canmb_rx_msg_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } canmb_ram_req_t;
endpackage : canmb_pkg

// [hw/canmb_buffer_ram.sv]
`timescale 1ns/1ps
// Overview of operation
// - All buffer words live in a dual-ported RAM array, never in separate registers.
// - Buffers 0 to 31 exist and word 0 holds the standard identifier in bits 12:2 with 15:13 zero.
// - Word 0 bit 1 is the substitute remote request flag.
// - Word 0 bit 0 chooses extended (1) or standard (0) identifier format.
// - Extended identifier bits 17:6 sit in word 1 bits 11:0 and bits 5:0 in word 2 bits 15:10.
// - Word 2 bits 3:0 hold the length code and bits 7:5 read zero.
// - Eight payload bytes pack two per word, the higher byte number in the upper half.
// - A received store writes the matched filter number into status bits 12:8 only.
// - Status bits 15:13 and 7:0 read zero.
// - A receive store sets the buffer full flag, cleared only by software or by srst.
// - Storing into a full buffer sets the overflow flag, cleared by software.
module canmb_buffer_ram (
  // Clock and control.
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Received messages from the controller core.
  input wire logic rxValid,
  output logic rxReady,
  input wire canmb_pkg::canmb_rx_msg_t rxMsg,
  // Software port of the dual-ported RAM.
  input wire canmb_pkg::canmb_ram_req_t swReq,
  output logic [15:0] swRdata,
  // Transmit read port for the controller core.
  input wire logic [7:0] txAddr,
  output logic [15:0] txRdata,
  // Full and overflow flags with write-one-to-clear strobes.
  input wire logic [31:0] fullClr,
  input wire logic [31:0] ovfClr,
  output logic [31:0] receiveBufferFullFlag,
  output logic [31:0] receiveBufferOverflowFlag
);
  logic [15:0] ram [canmb_pkg::NumBuffers * canmb_pkg::WordsPerBuf];
  logic fifoValid;
  logic fifoReady;
  canmb_pkg::canmb_rx_msg_t cur;
  logic [2:0] wordCnt_q;
  logic [15:0] rxWord;
  logic [15:0] swMask;
  logic [31:0] fullSet;
  logic [31:0] ovfSet;
  logic storeDone;

  // Back-pressure: a 16-deep FIFO queues messages; the core stalls only while it is full.
  canmb_fifo #(.Width($bits(canmb_pkg::canmb_rx_msg_t)), .Depth(canmb_pkg::FifoDepth)) uFifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .clkEn(clkEn),
    .inValid(rxValid),
    .inReady(rxReady),
    .inData(rxMsg),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(cur)
  );

  always_comb
  begin
    rxWord = '0;
    unique case (wordCnt_q)
      canmb_pkg::WordStdId:
      begin
        rxWord[canmb_pkg::StdIdLsb +: 11] = cur.standardIdentifier;
        rxWord[canmb_pkg::SubRemoteBit] = cur.subRemote;
        rxWord[canmb_pkg::IdFormatBit] = cur.idExtended;
      end
      canmb_pkg::WordExtId:
        rxWord[canmb_pkg::ExtHiLsb +: 12] = cur.extendedIdentifier[17:6];
      canmb_pkg::WordLenCode:
      begin
        rxWord[canmb_pkg::ExtLoLsb +: 6] = cur.extendedIdentifier[5:0];
        rxWord[canmb_pkg::RemoteReqBit] = cur.remoteReq;
        rxWord[canmb_pkg::ResHighBit] = 1'b0;
        rxWord[canmb_pkg::ResLowBit] = 1'b0;
        rxWord[canmb_pkg::LenCodeLsb +: 4] = cur.lenCode;
      end
      canmb_pkg::WordStatus:
        rxWord[canmb_pkg::FilterLsb +: 5] = cur.matchedFilterNumber;
      default:
        rxWord = cur.payload[16*(32'(wordCnt_q) - 32'(canmb_pkg::WordData01)) +: 16];
    endcase
  end

  // Write masks keep unimplemented bits at zero so reads return zero.
  function automatic logic [15:0] wordMask(input logic [2:0] w);
    unique case (w)
      canmb_pkg::WordStdId: wordMask = canmb_pkg::MaskStdId;
      canmb_pkg::WordExtId: wordMask = canmb_pkg::MaskExtId;
      canmb_pkg::WordLenCode: wordMask = canmb_pkg::MaskLenCode;
      canmb_pkg::WordStatus: wordMask = canmb_pkg::MaskStatus;
      default: wordMask = canmb_pkg::MaskData;
    endcase
  endfunction : wordMask

  assign swMask = wordMask(swReq.addr[2:0]);
  assign storeDone = fifoValid && (wordCnt_q == canmb_pkg::WordStatus);
  assign fifoReady = storeDone;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wordCnt_q <= '0;
    end
    else if (clkEn && fifoValid)
    begin
      wordCnt_q <= wordCnt_q + 3'h1;
    end
  end

  // The controller port wins a same-cycle collision on the same word; software must
  // not write a buffer whose full flag is set.
  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      if (fifoValid)
      begin
        ram[{cur.bufIndex, wordCnt_q}] <= rxWord;
      end
      if (swReq.req && swReq.wr && !(fifoValid && swReq.addr == {cur.bufIndex, wordCnt_q}))
      begin
        ram[swReq.addr] <= swReq.wdata & swMask;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      swRdata <= '0;
      txRdata <= '0;
    end
    else if (clkEn)
    begin
      if (swReq.req && !swReq.wr)
      begin
        swRdata <= ram[swReq.addr] & swMask;
      end
      txRdata <= ram[txAddr] & wordMask(txAddr[2:0]);
    end
  end

  always_comb
  begin
    fullSet = '0;
    ovfSet = '0;
    if (storeDone)
    begin
      fullSet[cur.bufIndex] = 1'b1;
      ovfSet[cur.bufIndex] = receiveBufferFullFlag[cur.bufIndex];
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      receiveBufferFullFlag <= '0;
      receiveBufferOverflowFlag <= '0;
    end
    else if (clkEn)
    begin
      receiveBufferFullFlag <= (receiveBufferFullFlag & ~fullClr) | fullSet;
      receiveBufferOverflowFlag <= (receiveBufferOverflowFlag & ~ovfClr) | ovfSet;
    end
  end
endmodule : canmb_buffer_ram

// [hw/canmb_fifo.sv]
`timescale 1ns/1ps
module canmb_fifo #(
  parameter int Width = 8,
  parameter int Depth = 16
) (
  // Clock and control.
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Fill side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  // Drain side.
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  localparam int AW = $clog2(Depth);
  logic [Width-1:0] mem [Depth];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != (AW+1)'(Depth));
  assign outValid = (count_q != '0);
  assign push = inValid && inReady && clkEn;
  assign pop = outValid && outReady && clkEn;
  assign outData = mem[rdPtr_q];

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : canmb_fifo

// [tb/canmb_buffer_ram_props.sv]
`timescale 1ns/1ps
module canmb_buffer_ram_props (
  // Watched ports.
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire canmb_pkg::canmb_ram_req_t swReq,
  input wire logic [15:0] swRdata,
  input wire logic [7:0] txAddr,
  input wire logic [15:0] txRdata,
  input wire logic [31:0] fullClr,
  input wire logic [31:0] ovfClr,
  input wire logic [31:0] receiveBufferFullFlag,
  input wire logic [31:0] receiveBufferOverflowFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic rd = swReq.req && !swReq.wr && clkEn;
  a_std_pad_zero:
    assert property (rd && swReq.addr[2:0] == 3'h0 |=> swRdata[15:13] == 3'h0) else $error("pad");
  a_ext_pad_zero:
    assert property (rd && swReq.addr[2:0] == 3'h1 |=> swRdata[15:12] == 4'h0) else $error("pad");
  a_len_pad_zero:
    assert property (rd && swReq.addr[2:0] == 3'h2 |=> swRdata[7:5] == 3'h0) else $error("pad");
  a_stat_pad_zero:
    assert property (rd && swReq.addr[2:0] == 3'h7 |=> (swRdata & 16'hE0FF) == 16'h0)
      else $error("pad");
  a_tx_stat_zero:
    assert property (clkEn && txAddr[2:0] == 3'h7 |=> txRdata[7:0] == 8'h0) else $error("pad");
  a_full_sw_clear:
    assert property (!$past(srst) |-> (~receiveBufferFullFlag & $past(receiveBufferFullFlag)
      & ~$past(fullClr)) == 32'h0) else $error("full lost");
  a_ovf_sw_clear:
    assert property (!$past(srst) |-> (~receiveBufferOverflowFlag
      & $past(receiveBufferOverflowFlag) & ~$past(ovfClr)) == 32'h0) else $error("ovf lost");
  a_ovf_needs_full:
    assert property (!$past(srst) |-> (receiveBufferOverflowFlag
      & ~$past(receiveBufferOverflowFlag) & ~$past(receiveBufferFullFlag)) == 32'h0)
      else $error("ovf early");
  c_rx_taken: cover property (rxValid && rxReady);
  c_fifo_full: cover property (rxValid && !rxReady);
  c_ovf: cover property ($rose(receiveBufferOverflowFlag[0]));
endmodule : canmb_buffer_ram_props
bind canmb_buffer_ram canmb_buffer_ram_props chk (.sys_clk, .srst, .clkEn, .rxValid, .rxReady,
  .swReq, .swRdata, .txAddr, .txRdata, .fullClr, .ovfClr, .receiveBufferFullFlag,
  .receiveBufferOverflowFlag);

// [tb/canmb_buffer_ram_tb.sv]
`timescale 1ns/1ps
module canmb_buffer_ram_tb;
  logic sys_clk = 0, srst = 1, clkEn = 1, rxValid, rxReady, rdSeen = 0;
  logic [31:0] fullClr = '0, ovfClr = '0;
  int seed = 32'h48F4;
  logic [31:0] receiveBufferFullFlag, receiveBufferOverflowFlag;
  logic [7:0] txAddr = 8'h07;
  logic [15:0] swRdata, txRdata, d, ev[8];
  logic [15:0] msk[8] = '{16'h1FFF, 16'h0FFF, 16'hFF1F, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'h1F00};
  logic [31:0] expQ[$];
  canmb_pkg::canmb_ram_req_t swReq = '0;
  canmb_pkg::canmb_rx_msg_t m, rxMsg;
  int fails = 0, checks_done = 0;
  initial forever #50 sys_clk = ~sys_clk;
  canmb_rx_source src (.sys_clk, .rxValid, .rxReady, .rxMsg);
  canmb_buffer_ram uut (.sys_clk, .srst, .clkEn, .rxValid, .rxReady, .rxMsg, .swReq, .swRdata,
    .txAddr, .txRdata, .fullClr, .ovfClr, .receiveBufferFullFlag, .receiveBufferOverflowFlag);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value at %0t: %h vs %h", $time, s, e);
    end
  endtask : check
  task automatic rw(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    swReq = '{1'b1, wr, a, wd};
    @(posedge sys_clk) #1;
  endtask : rw
  task automatic readBuf(input logic [4:0] b);
    for (int w = 0; w < 8; w++)
    begin
      rw(1'b0, {b, 3'(w)}, 16'h0);
      expQ.push_back({16'h0, ev[w]});
    end
    swReq.req = 1'b0;
  endtask : readBuf
  task complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  always @(posedge sys_clk)
  begin
    if (rdSeen)
      check({16'h0, swRdata}, expQ.pop_front());
    rdSeen <= swReq.req && !swReq.wr;
  end
  initial
  begin
    #2000000 fails++;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1 srst = 0;
    for (int w = 0; w < 8; w++)
    begin
      d = 16'($random(seed)) & (w == 2 ? 16'hFEEF : 16'hFFFF);
      ev[w] = d & msk[w];
      rw(1'b1, {5'h09, 3'(w)}, d);
    end
    readBuf(5'h09);
    for (int i = 0; i < 20; i++)
    begin
      m = 110'({$random(seed), $random(seed), $random(seed), $random(seed)});
      m.bufIndex = 5'(i);
      src.send(m, 0);
      ev[0] = {3'h0, m.standardIdentifier, m.subRemote, m.idExtended};
      ev[1] = {4'h0, m.extendedIdentifier[17:6]};
      ev[2] = {m.extendedIdentifier[5:0], m.remoteReq, 5'h0, m.lenCode};
      for (int k = 0; k < 4; k++)
        ev[3 + k] = m.payload[16 * k +: 16];
      ev[7] = {3'h0, m.matchedFilterNumber, 8'h0};
    end
    m.bufIndex = 5'h00;
    src.send(m, 5);
    for (int k = 0; k < 500 && !receiveBufferOverflowFlag[0]; k++)
      @(posedge sys_clk) #1;
    check(receiveBufferFullFlag, 32'h000FFFFF);
    check(receiveBufferOverflowFlag, 32'h1);
    readBuf(5'h13);
    // With the clock enable low a clear must not act.
    clkEn = 1'b0;
    fullClr = '1;
    ovfClr = '1;
    @(posedge sys_clk) #1;
    check(receiveBufferFullFlag, 32'h000FFFFF);
    check(receiveBufferOverflowFlag, 32'h1);
    clkEn = 1'b1;
    txAddr = {5'h13, 3'h7};
    @(posedge sys_clk) #1;
    fullClr = '0;
    ovfClr = '0;
    check(receiveBufferFullFlag, 32'h0);
    check(receiveBufferOverflowFlag, 32'h0);
    check({16'h0, txRdata}, {16'h0, ev[7]});
    complete_run;
  end
endmodule : canmb_buffer_ram_tb

// [tb/canmb_rx_source.sv]
`timescale 1ns/1ps
module canmb_rx_source (
  // Clock.
  input wire logic sys_clk,
  // Stream into the buffers.
  output logic rxValid,
  input wire logic rxReady,
  output canmb_pkg::canmb_rx_msg_t rxMsg
);
  initial rxValid = 1'b0;
  initial rxMsg = '0;
  // Idle fields are inverted so a stale message can never match by luck.
  // Called one delay step after a rising edge; returns at the same phase.
  // One idle edge follows each message so valid never toggles twice in one step.
  task automatic send(input canmb_pkg::canmb_rx_msg_t m, input int gap);
    repeat (gap) @(posedge sys_clk) #1;
    rxValid = 1'b1;
    rxMsg = m;
    do @(posedge sys_clk); while (!rxReady);
    #1 rxValid = 1'b0;
    rxMsg = ~m;
    @(posedge sys_clk) #1;
  endtask : send
endmodule : canmb_rx_source
